/* core/lcdt_frame_div.sv */
// Divide-by-24 frame position counter with cascade resync
`include "lcdt_map.svh"
`default_nettype none

module lcdt_frame_div (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic tick,
   input wire logic restart,
   output logic [4:0] pos,
   output logic frame_start
);

   logic [4:0] pos_reg;
   logic [4:0] pos_next;

   assign pos = pos_reg;

   // Wrap to position zero is the frame boundary
   assign frame_start = tick && !restart && (pos_reg == `LCDT_LAST_POS);

   always_comb begin
      if (!tick) begin
         pos_next = pos_reg;
      end else if (restart) begin
         // A peer already sits in position zero
         pos_next = `LCDT_SYNC_POS;
      end else if (pos_reg == `LCDT_LAST_POS) begin
         pos_next = 5'h00;
      end else begin
         pos_next = pos_reg + 5'h01;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pos_reg <= 5'h00;
      end else if (clk_en) begin
         pos_reg <= pos_next;
      end
   end

endmodule : lcdt_frame_div

`default_nettype wire

/* core/lcdt_map.svh */
// Constants for the LCD multiplex drive timing core
`ifndef LCDT_MAP_SVH
`define LCDT_MAP_SVH

// Sizes of the panel side
`define LCDT_SEGS 60
`define LCDT_BPS 4
`define LCDT_ROW_W 4
`define LCDT_ADDR_W 6
`define LCDT_LVL_W 2

// Frame division of the timing clock
`define LCDT_FRAME_DIV 24
`define LCDT_HALF_TICKS 4'hC
`define LCDT_LAST_POS 5'h17
`define LCDT_SYNC_POS 5'h01

// Timing-clock ticks per backplane slot in each half-frame
`define LCDT_TPS_STATIC 4'hC
`define LCDT_TPS_MUX2 4'h6
`define LCDT_TPS_MUX3 4'h4
`define LCDT_TPS_MUX4 4'h3

// System clock and nominal timing clock (24 x 64 Hz)
`define LCDT_CLK_PERIOD_NS 40
`define LCDT_OSC_PERIOD_NS 651041
`define LCDT_OSC_CYCLES (`LCDT_OSC_PERIOD_NS / `LCDT_CLK_PERIOD_NS)
`define LCDT_OSC_HALF_CYCLES (`LCDT_OSC_CYCLES / 2)
`define LCDT_OSC_CNT_W 16

// Power-on drive configuration
`define LCDT_RST_MODE 2'h0
`define LCDT_RST_BIAS_HALF 1'b1
`define LCDT_RST_DISP_ON 1'b0

`endif

/* core/lcdt_pkg.sv */
// Types shared by the LCD multiplex drive timing core
`default_nettype none

package lcdt_pkg;

   // Drive mode as carried by the decoded mode-set command
   typedef enum logic [1:0] {
      LCDT_MUX4 = 2'b00,
      LCDT_STATIC = 2'b01,
      LCDT_MUX2 = 2'b10,
      LCDT_MUX3 = 2'b11
   } lcdt_mode_t;

   // Voltage level selection, ground up to panel supply
   typedef enum logic [1:0] {
      LCDT_LVL0 = 2'b00,
      LCDT_LVL1 = 2'b01,
      LCDT_LVL2 = 2'b10,
      LCDT_LVL3 = 2'b11
   } lcdt_level_t;

   // Strap capture after reset release
   typedef enum logic [0:0] {
      LCDT_CAP_WAIT = 1'b0,
      LCDT_CAP_HELD = 1'b1
   } lcdt_cap_t;

endpackage : lcdt_pkg

`default_nettype wire

/* core/lcdt_timing.sv */
// Timing and drive-level selection core of a segment LCD driver
`include "lcdt_map.svh"
`default_nettype none

module lcdt_timing #(
   parameter logic [`LCDT_OSC_CNT_W-1:0] OSC_HALF_CYCLES =
      `LCDT_OSC_CNT_W'(`LCDT_OSC_HALF_CYCLES)
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic mode_set,
   input wire logic [1:0] mode_code,
   input wire logic bias_half,
   input wire logic display_on,
   input wire logic ram_wr,
   input wire logic [`LCDT_ADDR_W-1:0] ram_addr,
   input wire logic [`LCDT_ROW_W-1:0] ram_data,
   input wire logic osc_strap,
   input wire logic clk_pin_i,
   output logic clk_pin_o,
   output logic clk_pin_oe,
   input wire logic sync_n_pin_i,
   output logic sync_n_pin_o,
   output logic sync_n_pin_oe,
   output logic frame_rate_tick,
   output logic [1:0] active_mode,
   output logic active_bias_half,
   output logic active_display_on,
   output logic [2*`LCDT_BPS-1:0] common_electrode_outputs,
   output logic [2*`LCDT_SEGS-1:0] element_electrode_outputs
);

   ////////////////////////////////////////////////////////////////////
   // Helpers

   // Timing-clock ticks in each backplane slot of a half-frame
   function automatic logic [3:0] slot_ticks(
      input lcdt_pkg::lcdt_mode_t m
   );
      case (m)
         lcdt_pkg::LCDT_STATIC: slot_ticks = `LCDT_TPS_STATIC;
         lcdt_pkg::LCDT_MUX2: slot_ticks = `LCDT_TPS_MUX2;
         lcdt_pkg::LCDT_MUX3: slot_ticks = `LCDT_TPS_MUX3;
         lcdt_pkg::LCDT_MUX4: slot_ticks = `LCDT_TPS_MUX4;
         default: slot_ticks = `LCDT_TPS_MUX4;
      endcase
   endfunction : slot_ticks

   // Slot in which a given common output is the selected one
   function automatic logic [1:0] bp_slot(
      input logic [1:0] b,
      input lcdt_pkg::lcdt_mode_t m
   );
      case (m)
         lcdt_pkg::LCDT_STATIC: bp_slot = 2'h0;
         lcdt_pkg::LCDT_MUX2: bp_slot = {1'b0, b[0]};
         lcdt_pkg::LCDT_MUX3: begin
            bp_slot = (b == 2'h3) ? 2'h1 : b;
         end
         lcdt_pkg::LCDT_MUX4: bp_slot = b;
         default: bp_slot = b;
      endcase
   endfunction : bp_slot

   // Mirror a level about mid-supply in the inverted half-frame
   function automatic lcdt_pkg::lcdt_level_t flip_level(
      input lcdt_pkg::lcdt_level_t lv,
      input logic half,
      input logic inv
   );
      if (!inv) begin
         flip_level = lv;
      end else if (half && (lv == lcdt_pkg::LCDT_LVL1)) begin
         // Half bias has one mid level, its own mirror
         flip_level = lv;
      end else begin
         flip_level = lcdt_pkg::lcdt_level_t'(~lv);
      end
   endfunction : flip_level

   ////////////////////////////////////////////////////////////////////
   // Strap capture

   lcdt_pkg::lcdt_cap_t cap_reg;
   logic strap_reg;

   // Strap is read once after reset release, never under the reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cap_reg <= lcdt_pkg::LCDT_CAP_WAIT;
         strap_reg <= 1'b1;
      end else if (clk_en) begin
         case (cap_reg)
            lcdt_pkg::LCDT_CAP_WAIT: begin
               strap_reg <= osc_strap;
               cap_reg <= lcdt_pkg::LCDT_CAP_HELD;
            end
            lcdt_pkg::LCDT_CAP_HELD: begin
               cap_reg <= lcdt_pkg::LCDT_CAP_HELD;
            end
            default: begin
               cap_reg <= lcdt_pkg::LCDT_CAP_WAIT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Timing clock source

   logic [`LCDT_OSC_CNT_W-1:0] osc_cnt_reg;
   logic osc_level_reg;
   logic osc_wrap;
   logic ext_prev_reg;
   logic tick_int;
   logic tick_ext;
   logic tick;

   assign osc_wrap = (osc_cnt_reg == OSC_HALF_CYCLES - 1'b1);

   // Internal oscillator as a divider of the system clock
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         osc_cnt_reg <= '0;
         osc_level_reg <= 1'b0;
      end else if (clk_en) begin
         if (osc_wrap) begin
            osc_cnt_reg <= '0;
            osc_level_reg <= !osc_level_reg;
         end else begin
            osc_cnt_reg <= osc_cnt_reg + 1'b1;
         end
      end
   end

   // Reset high: a clock pin already high at release is not an edge
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_prev_reg <= 1'b1;
      end else if (clk_en) begin
         ext_prev_reg <= clk_pin_i;
      end
   end

   assign tick_int = osc_wrap && !osc_level_reg;
   assign tick_ext = clk_pin_i && !ext_prev_reg;

   // One timing clock for all drive logic
   assign tick = strap_reg ? tick_ext : tick_int;

   // Oscillator goes out for cascaded companions
   assign clk_pin_o = osc_level_reg;
   assign clk_pin_oe = !strap_reg;

   // A stopped external clock freezes the waveform: the far side's duty

   ////////////////////////////////////////////////////////////////////
   // Frame position and cascade sync

   logic [4:0] pos;
   logic frame_start;
   logic restart;
   logic sync_oe_reg;
   logic frame_tick_reg;

   // Low sync from a peer while we are not driving means its frame began
   assign restart = !sync_n_pin_i && !sync_oe_reg;

   lcdt_frame_div u_frame_div (
      .clock(clock),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .tick(tick),
      .restart(restart),
      .pos(pos),
      .frame_start(frame_start)
   );

   // Pull sync low through position zero of each own frame
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync_oe_reg <= 1'b0;
      end else if (clk_en && tick) begin
         sync_oe_reg <= frame_start;
      end
   end

   // Open-drain: only ever pulls low
   assign sync_n_pin_o = 1'b0;
   assign sync_n_pin_oe = sync_oe_reg;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         frame_tick_reg <= 1'b0;
      end else if (clk_en) begin
         frame_tick_reg <= frame_start;
      end
   end

   assign frame_rate_tick = frame_tick_reg;

   ////////////////////////////////////////////////////////////////////
   // Drive configuration

   lcdt_pkg::lcdt_mode_t pend_mode_reg;
   logic pend_half_reg;
   logic pend_on_reg;
   lcdt_pkg::lcdt_mode_t act_mode_reg;
   logic act_half_reg;
   logic act_on_reg;

   // Held until the frame ends so no frame mixes two slot plans
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pend_mode_reg <= lcdt_pkg::lcdt_mode_t'(`LCDT_RST_MODE);
         pend_half_reg <= `LCDT_RST_BIAS_HALF;
         pend_on_reg <= `LCDT_RST_DISP_ON;
      end else if (clk_en && mode_set) begin
         pend_mode_reg <= lcdt_pkg::lcdt_mode_t'(mode_code);
         pend_half_reg <= bias_half;
         pend_on_reg <= display_on;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         act_mode_reg <= lcdt_pkg::lcdt_mode_t'(`LCDT_RST_MODE);
         act_half_reg <= `LCDT_RST_BIAS_HALF;
         act_on_reg <= `LCDT_RST_DISP_ON;
      end else if (clk_en && frame_start) begin
         act_mode_reg <= pend_mode_reg;
         act_half_reg <= pend_half_reg;
         act_on_reg <= pend_on_reg;
      end
   end

   assign active_mode = act_mode_reg;
   assign active_bias_half = act_half_reg;
   assign active_display_on = act_on_reg;

   ////////////////////////////////////////////////////////////////////
   // Display memory and display register

   logic [`LCDT_ROW_W-1:0] ram_mem [0:`LCDT_SEGS-1];
   logic [`LCDT_ROW_W-1:0][`LCDT_SEGS-1:0] disp_reg;

   // Columns past the last element are dropped
   always_ff @(posedge clock) begin
      if (clk_en && ram_wr && (ram_addr < `LCDT_ADDR_W'(`LCDT_SEGS))) begin
         ram_mem[ram_addr] <= ram_data;
      end
   end

   // Memory starts unknown; the display is off until a mode set turns it on
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         disp_reg <= '0;
      end else if (clk_en && frame_start) begin
         for (int s = 0; s < `LCDT_SEGS; s++) begin
            for (int r = 0; r < `LCDT_ROW_W; r++) begin
               disp_reg[r][s] <= ram_mem[s][r];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Level selection

   logic inv;
   logic [3:0] idx;
   logic [1:0] slot;
   lcdt_pkg::lcdt_level_t lv;
   lcdt_pkg::lcdt_level_t seg_off;
   logic [2*`LCDT_BPS-1:0] bp_next;
   logic [2*`LCDT_SEGS-1:0] seg_next;
   logic [2*`LCDT_BPS-1:0] bp_reg;
   logic [2*`LCDT_SEGS-1:0] seg_reg;

   // Second half-frame repeats the slots with the polarity turned round
   assign inv = (pos >= 5'(`LCDT_HALF_TICKS));
   assign idx = inv ? 4'(pos - 5'(`LCDT_HALF_TICKS)) : 4'(pos);
   assign slot = 2'(idx / slot_ticks(act_mode_reg));

   // Off-state element level: full swing unless third bias multiplexes
   always_comb begin
      if ((act_mode_reg == lcdt_pkg::LCDT_STATIC) || act_half_reg) begin
         seg_off = lcdt_pkg::LCDT_LVL3;
      end else begin
         seg_off = lcdt_pkg::LCDT_LVL2;
      end
   end

   always_comb begin
      bp_next = '0;
      seg_next = '0;
      lv = lcdt_pkg::LCDT_LVL3;
      for (int b = 0; b < `LCDT_BPS; b++) begin
         if (!act_on_reg) begin
            lv = lcdt_pkg::LCDT_LVL3;
         end else if (act_mode_reg == lcdt_pkg::LCDT_STATIC) begin
            lv = lcdt_pkg::LCDT_LVL3;
         end else if (bp_slot(2'(b), act_mode_reg) == slot) begin
            lv = lcdt_pkg::LCDT_LVL3;
         end else begin
            // Unselected commons sit at the low bias step
            lv = lcdt_pkg::LCDT_LVL1;
         end
         if (act_on_reg) begin
            lv = flip_level(lv, act_half_reg, inv);
         end
         bp_next[2*b +: 2] = lv;
      end
      for (int s = 0; s < `LCDT_SEGS; s++) begin
         if (!act_on_reg) begin
            lv = lcdt_pkg::LCDT_LVL3;
         end else if (disp_reg[slot][s]) begin
            lv = lcdt_pkg::LCDT_LVL0;
         end else begin
            lv = seg_off;
         end
         if (act_on_reg) begin
            lv = flip_level(lv, act_half_reg, inv);
         end
         seg_next[2*s +: 2] = lv;
      end
   end

   // Outputs held in flops; reset parks every pin on panel supply
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bp_reg <= '1;
         seg_reg <= '1;
      end else if (clk_en) begin
         bp_reg <= bp_next;
         seg_reg <= seg_next;
      end
   end

   assign common_electrode_outputs = bp_reg;
   assign element_electrode_outputs = seg_reg;

endmodule : lcdt_timing

`default_nettype wire

/* testbench/lcdt_peer.sv */
// Cascade peer model: free-running timing clock and sync pull-down
`default_nettype none

module lcdt_peer (
   input wire logic run_clk,
   input wire logic pull_req,
   output var logic clk_out,
   output logic sync_pull
);
   timeunit 1ns;
   timeprecision 1ns;

   initial clk_out = 1'b0;
   // Never paused while selected: a stopped clock leaves DC on the glass
   always #160 clk_out = run_clk ? !clk_out : 1'b0;
   assign sync_pull = pull_req;
endmodule : lcdt_peer

`default_nettype wire

/* testbench/lcdt_properties.sv */
// Port-level checks of the LCD timing core
`include "lcdt_map.svh"
`default_nettype none

module lcdt_props #(
   parameter logic [`LCDT_OSC_CNT_W-1:0] OSC_HALF_CYCLES = 16'h0004
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic clk_pin_o,
   input wire logic clk_pin_oe,
   input wire logic sync_n_pin_o,
   input wire logic sync_n_pin_oe,
   input wire logic frame_rate_tick,
   input wire logic [1:0] active_mode,
   input wire logic active_display_on,
   input wire logic [2*`LCDT_BPS-1:0] common_electrode_outputs,
   input wire logic [2*`LCDT_SEGS-1:0] element_electrode_outputs
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic osc_prev_reg;
   logic [15:0] still_reg;
   wire logic [7:0] bp = common_electrode_outputs;

   ////////////////////////////////////////////////////////////////////
   // Cycles since the driven clock pin last moved; a freeze restarts it
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         osc_prev_reg <= 1'b0;
         still_reg <= 16'h0000;
      end else begin
         osc_prev_reg <= clk_pin_o;
         still_reg <= (clk_pin_o != osc_prev_reg || !clk_pin_oe ||
            !clk_en) ? 16'h0000 : still_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   a_reset_defaults: assert property ($rose(reset_n) |-> bp == 8'hFF &&
      &element_electrode_outputs && active_mode == 2'h0 && !active_display_on)
      else $error("outputs not at power-on state");
   a_blank_flat: assert property (!active_display_on &&
      !$past(active_display_on) |-> bp == 8'hFF && &element_electrode_outputs)
      else $error("blank display not flat");
   a_static_commons: assert property (active_mode == 2'h1 &&
      $past(active_mode) == 2'h1 |-> bp == {4{bp[1:0]}} &&
      (bp[1:0] == 2'h0 || bp[1:0] == 2'h3))
      else $error("static commons differ");
   a_duplex_pairs: assert property (active_mode == 2'h2 &&
      $past(active_mode) == 2'h2 |-> bp[7:4] == bp[3:0])
      else $error("duplex pairs differ");
   a_triplex_copy: assert property (active_mode == 2'h3 &&
      $past(active_mode) == 2'h3 |-> bp[7:6] == bp[3:2])
      else $error("fourth common not a copy of second");
   a_tick_single: assert property (frame_rate_tick |=> !frame_rate_tick)
      else $error("frame pulse too long");
   a_sync_follows: assert property (frame_rate_tick |->
      sync_n_pin_oe && !sync_n_pin_o)
      else $error("sync not pulled at frame start");
   a_osc_toggle: assert property (still_reg <= OSC_HALF_CYCLES)
      else $error("driven clock pin stalled");
endmodule : lcdt_props

bind lcdt_timing lcdt_props #(.OSC_HALF_CYCLES(OSC_HALF_CYCLES)) u_props (
   .clock(clock), .reset_n(reset_n), .clk_en(clk_en),
   .clk_pin_o(clk_pin_o),
   .clk_pin_oe(clk_pin_oe), .sync_n_pin_o(sync_n_pin_o),
   .sync_n_pin_oe(sync_n_pin_oe), .frame_rate_tick(frame_rate_tick),
   .active_mode(active_mode), .active_display_on(active_display_on),
   .common_electrode_outputs(common_electrode_outputs),
   .element_electrode_outputs(element_electrode_outputs));

`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the LCD multiplex timing core
`include "lcdt_map.svh"
`default_nettype none
`define CHK(n, e, g) cmp(n, 128'(e), 128'(g))

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] HALF = 16'h0004;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic mode_set = 1'b0, bias_half = 1'b0, display_on = 1'b0;
   logic ram_wr = 1'b0, osc_strap = 1'b0, run_clk = 1'b0, pull_req = 1'b0;
   logic clk_en = 1'b1;
   logic [1:0] mode_code = 2'h0, pm, am;
   logic [5:0] ram_addr = 6'h00;
   logic [3:0] ram_data = 4'h0;
   logic ph, ah, pon, aon;
   logic [3:0] mem_exp [60];
   logic [3:0] disp_exp [60];
   logic [1:0] cfg_m [7] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h2, 2'h2, 2'h1};
   logic [6:0] cfg_h = 7'h1A;
   wire logic clk_pin_o, clk_pin_oe, sync_n_pin_o, sync_n_pin_oe, ftick;
   wire logic peer_clk, sync_pull, ab, ad;
   wire logic [1:0] amode;
   wire logic [7:0] bp_out;
   wire logic [119:0] seg_out;
   // Pin levels: driven clock wins, sync line has a pull-up
   wire logic clk_pin = clk_pin_oe ? clk_pin_o : peer_clk;
   wire logic sync_n = !((sync_n_pin_oe && !sync_n_pin_o) || sync_pull);
   int fails = 0, n_checks = 0, cycles = 0;

   lcdt_timing #(.OSC_HALF_CYCLES(HALF)) u_dut (.clock(clock),
      .reset_n(reset_n), .clk_en(clk_en), .mode_set(mode_set),
      .mode_code(mode_code), .bias_half(bias_half), .display_on(display_on),
      .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_data(ram_data),
      .osc_strap(osc_strap), .clk_pin_i(clk_pin), .clk_pin_o(clk_pin_o),
      .clk_pin_oe(clk_pin_oe), .sync_n_pin_i(sync_n),
      .sync_n_pin_o(sync_n_pin_o), .sync_n_pin_oe(sync_n_pin_oe),
      .frame_rate_tick(ftick), .active_mode(amode), .active_bias_half(ab),
      .active_display_on(ad), .common_electrode_outputs(bp_out),
      .element_electrode_outputs(seg_out));
   lcdt_peer u_peer (.run_clk(run_clk), .pull_req(pull_req),
      .clk_out(peer_clk), .sync_pull(sync_pull));

   always #20 clock = !clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         fails++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////
   task automatic cmp(input string n, input logic [127:0] e,
      input logic [127:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   // Inverted half-frame mirrors codes; half-bias mid level has no mirror
   function automatic logic [1:0] flip(logic [1:0] c, int p, logic keep);
      return (p >= 12 && !keep) ? ~c : c;
   endfunction : flip

   function automatic logic [127:0] expect_out(int p);
      logic [127:0] v;
      logic [1:0] c;
      logic st;
      int s, bs;
      v = '1;
      st = am == lcdt_pkg::LCDT_STATIC;
      s = (p % 12) / (st ? 12 : am == lcdt_pkg::LCDT_MUX2 ? 6 :
         am == lcdt_pkg::LCDT_MUX3 ? 4 : 3);
      if (!aon) return v;
      for (int b = 0; b < 4; b++) begin
         bs = am == lcdt_pkg::LCDT_MUX4 ? b : am == lcdt_pkg::LCDT_MUX3 ?
            (b == 3 ? 1 : b) : am == lcdt_pkg::LCDT_MUX2 ? b % 2 : 0;
         c = (st || bs == s) ? 2'h3 : 2'h1;
         v[2*b +: 2] = flip(c, p, c == 2'h1 && ah);
      end
      for (int i = 0; i < 60; i++)
         v[8+2*i +: 2] = flip(disp_exp[i][s] ? 2'h0 :
            (st || ah) ? 2'h3 : 2'h2, p, 1'b0);
      return v;
   endfunction : expect_out

   ////////////////////////////////////////////////////////////////////
   task automatic wait_tick();
      int n;
      n = 0;
      while (ftick !== 1'b1 && n < 400) begin
         @(negedge clock);
         n++;
      end
      `CHK("frame wait", 1'b1, ftick);
   endtask : wait_tick

   task automatic fill_mem(input logic [3:0] k);
      for (int c = 0; c < 64; c++) begin
         ram_wr = 1'b1;
         ram_addr = 6'(c);
         ram_data = c < 60 ? 4'(c * 5) ^ k : 4'hF;
         if (c < 60) mem_exp[c] = ram_data;
         @(negedge clock);
      end
      ram_wr = 1'b0;
   endtask : fill_mem

   task automatic do_reset(input logic strap);
      reset_n = 1'b0;
      osc_strap = strap;
      repeat (3) @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      `CHK("reset cfg", 4'h2, {amode, ab, ad});
      `CHK("reset commons", 8'hFF, bp_out);
      repeat (2) @(negedge clock);
      `CHK("clock pin drive", !strap, clk_pin_oe);
      {pm, ph, pon} = 4'h2;
      fill_mem(4'(strap));
      $display("test reset done");
   endtask : do_reset

   task automatic set_mode(input logic [1:0] m, input logic h, input logic on);
      mode_code = m;
      bias_half = h;
      display_on = on;
      mode_set = 1'b1;
      {pm, ph, pon} = {m, h, on};
      @(negedge clock);
      mode_set = 1'b0;
   endtask : set_mode

   // Rewrites column 0 mid-frame; the old value must stay on the glass
   task automatic run_frame(input string name);
      logic [127:0] v;
      wait_tick();
      {am, ah, aon} = {pm, ph, pon};
      `CHK("active cfg", {pm, ph, pon}, {amode, ab, ad});
      disp_exp = mem_exp;
      repeat (4) @(negedge clock);
      for (int p = 0; p < 24; p++) begin
         v = expect_out(p);
         `CHK("commons", v[7:0], bp_out);
         `CHK("elements", v[127:8], seg_out);
         if (p == 6) begin
            ram_wr = 1'b1;
            ram_addr = 6'h00;
            ram_data = ~mem_exp[0];
            mem_exp[0] = ram_data;
         end
         @(negedge clock);
         ram_wr = 1'b0;
         repeat (7) @(negedge clock);
      end
      $display("test %s done", name);
   endtask : run_frame

   task automatic measure_frame();
      int n;
      wait_tick();
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (ftick !== 1'b1 && n < 400);
      `CHK("frame length", 48 * HALF, n);
      $display("test frame length done");
   endtask : measure_frame

   // Freeze across the half-frame flip: outputs hold, frame stretches
   task automatic freeze_test();
      logic [7:0] held;
      int n;
      wait_tick();
      repeat (90) @(negedge clock);
      held = bp_out;
      clk_en = 1'b0;
      repeat (40) @(negedge clock);
      `CHK("frozen commons", held, bp_out);
      clk_en = 1'b1;
      n = 130;
      while (ftick !== 1'b1 && n < 400) begin
         @(negedge clock);
         n++;
      end
      `CHK("frozen frame", 48 * HALF + 40, n);
      $display("test freeze done");
   endtask : freeze_test

   // Peer pulls sync mid-frame; own frame must restart at position one
   task automatic sync_test();
      int n;
      wait_tick();
      repeat (100) @(negedge clock);
      pull_req = 1'b1;
      repeat (8) @(negedge clock);
      pull_req = 1'b0;
      n = 8;
      while (ftick !== 1'b1 && n < 400) begin
         @(negedge clock);
         n++;
      end
      `CHK("resync frame", 1'b1, n > 176 && n < 200);
      $display("test sync done");
   endtask : sync_test

   ////////////////////////////////////////////////////////////////////
   initial begin
      do_reset(1'b0);
      measure_frame();
      for (int i = 0; i < 7; i++) begin
         set_mode(cfg_m[i], cfg_h[i], 1'b1);
         run_frame("mode");
      end
      freeze_test();
      set_mode(2'h0, 1'b0, 1'b0);
      run_frame("blank");
      sync_test();
      run_clk = 1'b1;
      do_reset(1'b1);
      set_mode(2'h3, 1'b0, 1'b1);
      run_frame("external");
      measure_frame();
      end_of_test();
   end
endmodule : tb_top

`default_nettype wire
